/* File: testbench/master_model.sv */
// Behavioural model of the DMA and processor bus masters
`timescale 1ns/1ps
module master_model (
  // Clock and broadcast answer
  input wire logic clk_i,
  input wire logic abort_i,
  input wire logic cpu_grant_i,
  // DMA master request
  output logic dma_req_o = 1'b0,
  output logic [31:0] dma_addr_o = 32'h0,
  output logic [1:0] dma_size_o = 2'h0,
  output logic dma_write_o = 1'b0,
  // Processor master request
  output logic cpu_req_o = 1'b0,
  output logic [31:0] cpu_addr_o = 32'h0,
  output logic [1:0] cpu_size_o = 2'h0,
  output logic [1:0] cpu_type_o = 2'h0,
  output logic cpu_priv_o = 1'b0,
  // Abort as the processor takes it
  output logic cpu_abort_o
);
  // DMA never looks at the abort; the processor only for its own granted access
  assign cpu_abort_o = abort_i & cpu_grant_i;
  // One request cycle; released address lines show the inverse, never stale data
  task automatic issue(input logic d, input logic [31:0] da, input logic [1:0] ds,
                       input logic dw, input logic c, input logic [31:0] ca,
                       input logic [1:0] cs, input logic [1:0] ct, input logic cp);
    @(posedge clk_i);
    dma_req_o <= d;
    dma_addr_o <= da;
    dma_size_o <= ds;
    dma_write_o <= dw;
    cpu_req_o <= c;
    cpu_addr_o <= ca;
    cpu_size_o <= cs;
    cpu_type_o <= ct;
    cpu_priv_o <= cp;
    @(posedge clk_i);
    dma_req_o <= 1'b0;
    cpu_req_o <= 1'b0;
    dma_addr_o <= ~da;
    cpu_addr_o <= ~ca;
  endtask
endmodule // master_model

/* File: testbench/system_bus_memory_controller_tb.sv */
// Self-checking testbench of the system bus memory controller
`timescale 1ns/1ps
module system_bus_memory_controller_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic boot_i = 1'b0;
  logic [31:0] dat_o, dma_addr, cpu_addr, mem_addr, q;
  logic ack_o, dma_req, dma_write, cpu_req, cpu_priv, dma_gnt, cpu_gnt, abort, cpu_abort;
  logic [1:0] dma_size, cpu_size, cpu_type;
  logic [2:0] target;
  logic [7:0] cs;
  int err_count = 0;
  int checked = 0;
  // Clock of 40 ns
  always #20 clk_i = ~clk_i;
  bus_memory_controller #(.ADDR_W(32)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .dma_req_i(dma_req), .dma_addr_i(dma_addr), .dma_size_i(dma_size),
    .dma_write_i(dma_write), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr), .cpu_size_i(cpu_size),
    .cpu_type_i(cpu_type), .cpu_priv_i(cpu_priv), .nonvolatile_boot_bit_i(boot_i),
    .dma_grant_o(dma_gnt), .cpu_grant_o(cpu_gnt), .abort_o(abort), .target_o(target),
    .chip_select_o(cs), .mem_addr_o(mem_addr));
  master_model u_masters (.clk_i(clk_i), .abort_i(abort), .cpu_grant_i(cpu_gnt),
    .dma_req_o(dma_req), .dma_addr_o(dma_addr), .dma_size_o(dma_size),
    .dma_write_o(dma_write), .cpu_req_o(cpu_req), .cpu_addr_o(cpu_addr),
    .cpu_size_o(cpu_size), .cpu_type_o(cpu_type), .cpu_priv_o(cpu_priv),
    .cpu_abort_o(cpu_abort));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Classic Wishbone cycle; waits on ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) err_count++;
  endtask
  // Processor-only access, judged one edge after the request cycle
  task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] ty,
                     input logic pv, input logic ab, input logic [2:0] tg);
    u_masters.issue(1'b0, 32'h0, 2'h0, 1'b0, 1'b1, a, sz, ty, pv);
    #1;
    check(abort, ab);
    check(target, tg);
  endtask
  function automatic logic [31:0] st(input int c, input logic [1:0] sz, input logic [1:0] ty,
                                     input int m);
    st = (32'h1 << c) | (32'(sz) << memctl_pkg::POS_SIZE) | (32'(ty) << memctl_pkg::POS_TYPE);
    st = st | (32'h1 << m);
  endfunction
  // Address map walk over every top nibble
  task automatic t_decode;
    for (int n = 0; n < 16; n++) begin
      acc({n[3:0], 28'h02A_BCD0}, 2'h2, 2'h0, 1'b1, n inside {[9:14]},
          n == 0 ? 3'h3 : n < 9 ? 3'h4 : n == 15 ? 3'h5 : 3'h0);
      check(cs, (n > 0 && n < 9) ? 32'h1 << (n - 1) : 32'h0);
      @(posedge clk_i);
      #1;
      check(cs, 32'h0);
    end
    acc(32'h002A_BCD0, 2'h2, 2'h0, 1'b1, 1'b0, 3'h3);
    check(mem_addr, 32'h000A_BCD0);
    acc(32'h0010_0004, 2'h2, 2'h0, 1'b1, 1'b0, 3'h2);
    acc(32'h0030_0003, 2'h0, 2'h0, 1'b1, 1'b0, 3'h1);
    check(mem_addr, 32'h0000_0003);
    acc(32'h0050_0000, 2'h0, 2'h0, 1'b1, 1'b1, 3'h0);
  endtask
  // Boot selection and remap toggling
  task automatic t_remap;
    acc(32'h0, 2'h2, 2'h2, 1'b1, 1'b0, 3'h1);
    @(posedge clk_i);
    boot_i <= 1'b1;
    acc(32'h0, 2'h2, 2'h2, 1'b1, 1'b0, 3'h2);
    wb(1'b1, memctl_pkg::OFF_REMAP, 32'h1);
    acc(32'h0, 2'h2, 2'h0, 1'b1, 1'b0, 3'h3);
    acc(32'h0010_0000, 2'h2, 2'h0, 1'b1, 1'b0, 3'h2);
    wb(1'b1, memctl_pkg::OFF_REMAP, 32'h0);
    acc(32'h0, 2'h2, 2'h0, 1'b1, 1'b0, 3'h3);
    wb(1'b1, memctl_pkg::OFF_REMAP, 32'h1);
    acc(32'h0, 2'h2, 2'h0, 1'b1, 1'b0, 3'h2);
  endtask
  // Both masters at once, then abort bookkeeping
  task automatic t_abort;
    u_masters.issue(1'b1, 32'h1000_0000, 2'h2, 1'b1, 1'b1, 32'h2000_0000, 2'h2, 2'h0, 1'b1);
    #1;
    check({dma_gnt, cpu_gnt, cs}, {2'b10, 8'h01});
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    acc(32'h0020_0002, 2'h2, 2'h2, 1'b1, 1'b0, 3'h3);
    check(cpu_gnt, 1'b1);
    acc(32'h0020_0002, 2'h2, 2'h0, 1'b1, 1'b1, 3'h0);
    check(cpu_abort, 1'b1);
    acc(32'h0020_0001, 2'h1, 2'h0, 1'b1, 1'b1, 3'h0);
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    check(q, st(memctl_pkg::POS_MISAL, 2'h1, 2'h0, memctl_pkg::POS_SRC_CPU) | 32'h0200_0000);
    wb(1'b0, memctl_pkg::OFF_ABORT_ADDR, 32'h0);
    check(q, 32'h0020_0001);
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    check(q, st(memctl_pkg::POS_MISAL, 2'h1, 2'h0, memctl_pkg::POS_SRC_CPU));
    u_masters.issue(1'b1, 32'h9000_0006, 2'h1, 1'b1, 1'b0, 32'h0, 2'h0, 2'h0, 1'b0);
    #1;
    check({abort, cpu_abort}, 2'b10);
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    check(q, st(memctl_pkg::POS_UNDEF, 2'h1, 2'h1, memctl_pkg::POS_SRC_DMA) | 32'h0100_0000);
  endtask
  // Protection unit: regions, overlap and peripheral setting
  task automatic t_access_permission;
    wb(1'b1, memctl_pkg::OFF_ACCESS_PERMISSION_ENABLE, 32'h1);
    acc(32'h0020_0000, 2'h2, 2'h0, 1'b1, 1'b1, 3'h0);
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    check(q[memctl_pkg::POS_ACCESS_PERMISSION], 1'b1);
    wb(1'b1, memctl_pkg::OFF_REGION0, 32'h0000_00C2);
    wb(1'b0, memctl_pkg::OFF_REGION0, 32'h0);
    check(q, 32'h0000_00C2);
    acc(32'h0020_0000, 2'h2, 2'h1, 1'b0, 1'b1, 3'h0);
    acc(32'h0020_0000, 2'h2, 2'h0, 1'b0, 1'b0, 3'h3);
    acc(32'h0020_0000, 2'h2, 2'h1, 1'b1, 1'b0, 3'h3);
    wb(1'b1, memctl_pkg::OFF_REGION0 + 8'h04, 32'h0000_0001);
    acc(32'h0000_0000, 2'h2, 2'h0, 1'b0, 1'b1, 3'h0);
    acc(32'h0000_0400, 2'h2, 2'h0, 1'b0, 1'b0, 3'h2);
    acc(32'hFFFF_F000, 2'h2, 2'h0, 1'b1, 1'b1, 3'h0);
    wb(1'b1, memctl_pkg::OFF_PERIPH_ACCESS_PERMISSION, 32'h1);
    acc(32'hFFFF_F000, 2'h2, 2'h0, 1'b1, 1'b0, 3'h5);
    acc(32'hFFFF_F000, 2'h2, 2'h0, 1'b0, 1'b1, 3'h0);
  endtask
  // Watchdog well beyond the expected run of about 150 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, memctl_pkg::OFF_ABORT_STATUS, 32'h0);
    check(q, 32'h0);
    wb(1'b0, memctl_pkg::OFF_ACCESS_PERMISSION_ENABLE, 32'h0);
    check(q, 32'h0);
    t_decode();
    t_remap();
    t_abort();
    t_access_permission();
    tally_and_finish();
  end
endmodule // system_bus_memory_controller_tb

/* File: verilog/bus_memory_controller.sv */
// System bus memory controller: arbiter, decoder, remap, alignment, protection, abort status
// How it works
// - Only little-endian ordering; byte lanes pass straight through.
// - DMA master always wins over processor when both request.
// - Top four address bits select one of 11 regions.
// - 0x0000_0000 to 0x0FFF_FFFF is internal memory.
// - Nibbles 1 to 8 drive external chip selects 0 to 7.
// - Nibbles 9 to 14 are undefined and abort.
// - Nibble 15 routes to the peripheral space.
// - Bits 27:20 select 1-Mbyte slots; small memories alias across the slot.
// - Unassigned internal slot aborts.
// - Before remap area 0 maps ROM or flash per boot bit.
// - After remap SRAM also appears at area 0; original address still works.
// - Writing one to remap bit toggles remap; zero does nothing.
// - Abort goes to both masters; only processor reacts.
// - Every abort captures the full 32-bit address.
// - Every abort records size, type, cause and source master.
// - Per-master sticky abort flags since last status read.
// - Protection disabled after reset until enable bit written one.
// - Sixteen regions over internal memory, sizes 1K to 4M.
// - Peripheral space has its own write and user protection.
// - Most restrictive setting wins; internal memory access outside all regions aborts.
// - Misaligned word or half access aborts; instruction fetches exempt.
`timescale 1ns/1ps
module bus_memory_controller #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // DMA master request
  input wire logic dma_req_i,
  input wire logic [ADDR_W-1:0] dma_addr_i,
  input wire logic [1:0] dma_size_i,
  input wire logic dma_write_i,
  // Processor master request
  input wire logic cpu_req_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [1:0] cpu_size_i,
  input wire logic [1:0] cpu_type_i,
  input wire logic cpu_priv_i,
  // Boot selection from nonvolatile bit 2
  input wire logic nonvolatile_boot_bit_i,
  // Decoded access result
  output logic dma_grant_o,
  output logic cpu_grant_o,
  output logic abort_o,
  output logic [2:0] target_o,
  output logic [7:0] chip_select_o,
  output logic [ADDR_W-1:0] mem_addr_o
);

  // Register state
  logic remap_q, remap_d;
  logic access_permission_en_q, access_permission_en_d;
  logic [1:0] periph_access_permission_q, periph_access_permission_d;
  logic [31:0] region_q [memctl_pkg::NUM_REGIONS];
  logic [31:0] region_d [memctl_pkg::NUM_REGIONS];
  logic [31:0] abort_addr_q, abort_addr_d;
  logic [17:0] abort_info_q, abort_info_d;
  logic sticky_dma_q, sticky_dma_d;
  logic sticky_cpu_q, sticky_cpu_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  // Access outputs
  logic dma_grant_q, dma_grant_d, cpu_grant_q, cpu_grant_d, abort_q, abort_d;
  logic [2:0] target_q, target_d;
  logic [7:0] cs_q, cs_d;
  logic [ADDR_W-1:0] maddr_q, maddr_d;

  // Selected access, DMA first
  logic sel_dma, sel_any;
  logic [31:0] a;
  logic [1:0] sz, ty;
  logic priv;
  assign sel_dma = dma_req_i;
  assign sel_any = dma_req_i | cpu_req_i;
  assign a = sel_dma ? dma_addr_i : cpu_addr_i;
  assign sz = sel_dma ? dma_size_i : cpu_size_i;
  assign ty = sel_dma ? (dma_write_i ? memctl_pkg::TY_WRITE : memctl_pkg::TY_READ) : cpu_type_i;
  assign priv = sel_dma ? 1'b1 : cpu_priv_i; // DMA is treated as privileged

  // Region hits: base compare above the region size; size code 0 = 1K up to 12 = 4M
  logic [memctl_pkg::NUM_REGIONS-1:0] hit;
  logic [1:0] hit_access_permission [memctl_pkg::NUM_REGIONS];
  genvar g;
  generate
    for (g = 0; g < memctl_pkg::NUM_REGIONS; g++) begin : g_region
      logic [3:0] rsz;
      logic [21:0] mask;
      assign rsz = region_q[g][memctl_pkg::POS_RSIZE +: 4];
      // Low size bits ignored; code 12 shifts out to zero so the whole 4M matches
      assign mask = ~((22'h00_0400 << rsz) - 22'h00_0001);
      assign hit[g] = (a[27:22] == 6'h00) &&
        (((a[21:0] ^ {region_q[g][21:10], 10'h000}) & mask) == 22'h00_0000) && (rsz <= 4'hC);
      assign hit_access_permission[g] = region_q[g][1:0];
    end
  endgenerate

  // Permission check for a two-bit protection code
  function automatic logic allowed(input logic [1:0] p, input logic pv, input logic wr);
    logic r;
    r = 1'b0;
    case (p)
      2'h1: r = pv;
      2'h2: r = pv | ~wr;
      2'h3: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Decode, alignment and protection
  logic undef, misal, pviol, wr;
  memctl_pkg::target_t tgt;
  logic [7:0] cs;
  logic [31:0] maddr;
  always_comb begin
    wr = (ty == memctl_pkg::TY_WRITE);
    undef = 1'b0;
    tgt = memctl_pkg::TGT_NONE;
    cs = 8'h00;
    maddr = a;
    if (a[31:28] == memctl_pkg::NIB_INTERNAL) begin
      if (a[27:20] == memctl_pkg::SLOT_AREA0) begin
        if (remap_q) tgt = memctl_pkg::TGT_SRAM;
        else if (nonvolatile_boot_bit_i) tgt = memctl_pkg::TGT_FLASH;
        else tgt = memctl_pkg::TGT_ROM;
      end else if (a[27:20] == memctl_pkg::SLOT_FLASH) tgt = memctl_pkg::TGT_FLASH;
      else if (a[27:20] == memctl_pkg::SLOT_SRAM) tgt = memctl_pkg::TGT_SRAM;
      else if (a[27:20] == memctl_pkg::SLOT_ROM) tgt = memctl_pkg::TGT_ROM;
      else undef = 1'b1;
      maddr = {12'h000, a[19:0]};
    end else if (a[31:28] <= memctl_pkg::NIB_CS_LAST) begin
      tgt = memctl_pkg::TGT_EXT;
      cs = 8'h01 << (a[31:28] - 4'h1);
    end else if (a[31:28] == memctl_pkg::NIB_PERIPH) begin
      tgt = memctl_pkg::TGT_PERIPH;
    end else begin
      undef = 1'b1;
    end
    // Fetches from the processor skip the alignment check
    misal = (ty != memctl_pkg::TY_FETCH) &&
      (((sz == memctl_pkg::SZ_WORD) && (a[1:0] != 2'h0)) ||
       ((sz == memctl_pkg::SZ_HALF) && a[0]));
    pviol = 1'b0;
    if (access_permission_en_q && !undef) begin
      if (tgt == memctl_pkg::TGT_PERIPH) begin
        pviol = !allowed(periph_access_permission_q, priv, wr);
      end else if (a[31:28] == memctl_pkg::NIB_INTERNAL) begin
        pviol = (hit == '0);
        for (int i = 0; i < memctl_pkg::NUM_REGIONS; i++) begin
          if (hit[i] && !allowed(hit_access_permission[i], priv, wr)) pviol = 1'b1;
        end
      end
    end
  end

  // Access outputs: grant, target and abort broadcast
  always_comb begin
    dma_grant_d = sel_dma;
    cpu_grant_d = cpu_req_i & ~dma_req_i;
    abort_d = sel_any & (undef | misal | pviol);
    target_d = (sel_any && !abort_d) ? 3'(tgt) : 3'(memctl_pkg::TGT_NONE);
    // No select without a live request, so a stale address cannot strobe a device
    cs_d = (sel_any && !abort_d) ? cs : 8'h00;
    maddr_d = maddr;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_grant_q <= 1'b0;
      cpu_grant_q <= 1'b0;
      abort_q <= 1'b0;
      target_q <= 3'h0;
      cs_q <= 8'h00;
      maddr_q <= '0;
    end else begin
      dma_grant_q <= dma_grant_d;
      cpu_grant_q <= cpu_grant_d;
      abort_q <= abort_d;
      target_q <= target_d;
      cs_q <= cs_d;
      maddr_q <= maddr_d;
    end
  end

  // Register slave and abort capture
  logic wr_acc, rd_acc;
  logic [31:0] wdat;
  assign wr_acc = cyc_i & stb_i & we_i & ~ack_q;
  assign rd_acc = cyc_i & stb_i & ~we_i & ~ack_q;
  always_comb begin
    for (int b = 0; b < 4; b++) wdat[b*8 +: 8] = sel_i[b] ? dat_i[b*8 +: 8] : 8'h00;
    remap_d = remap_q;
    access_permission_en_d = access_permission_en_q;
    periph_access_permission_d = periph_access_permission_q;
    region_d = region_q;
    abort_addr_d = abort_addr_q;
    abort_info_d = abort_info_q;
    sticky_dma_d = sticky_dma_q;
    sticky_cpu_d = sticky_cpu_q;
    ack_d = cyc_i & stb_i & ~ack_q;
    dat_d = 32'h0000_0000;
    if (wr_acc) begin
      if (adr_i == memctl_pkg::OFF_REMAP) begin
        if (wdat[0]) remap_d = ~remap_q;
      end else if (adr_i == memctl_pkg::OFF_PERIPH_ACCESS_PERMISSION) begin
        periph_access_permission_d = wdat[1:0];
      end else if (adr_i == memctl_pkg::OFF_ACCESS_PERMISSION_ENABLE) begin
        access_permission_en_d = wdat[0];
      end else if (adr_i >= memctl_pkg::OFF_REGION0 && adr_i < memctl_pkg::OFF_PERIPH_ACCESS_PERMISSION &&
                   adr_i[1:0] == 2'h0) begin
        region_d[adr_i[5:2] - 4'h4] = wdat & 32'h003F_FCF3;
      end
    end
    if (rd_acc) begin
      if (adr_i == memctl_pkg::OFF_ABORT_STATUS) begin
        dat_d = {6'h00, sticky_cpu_q, sticky_dma_q, 6'h00, abort_info_q[17:16],
                 4'h0, abort_info_q[11:8], 5'h00, abort_info_q[2:0]};
        sticky_dma_d = 1'b0;
        sticky_cpu_d = 1'b0;
      end else if (adr_i == memctl_pkg::OFF_ABORT_ADDR) begin
        dat_d = abort_addr_q;
      end else if (adr_i == memctl_pkg::OFF_PERIPH_ACCESS_PERMISSION) begin
        dat_d = {30'h0, periph_access_permission_q};
      end else if (adr_i == memctl_pkg::OFF_ACCESS_PERMISSION_ENABLE) begin
        dat_d = {31'h0, access_permission_en_q};
      end else if (adr_i == memctl_pkg::OFF_BOOT_STATUS) begin
        dat_d = {30'h0, nonvolatile_boot_bit_i, remap_q};
      end else if (adr_i >= memctl_pkg::OFF_REGION0 && adr_i < memctl_pkg::OFF_PERIPH_ACCESS_PERMISSION) begin
        dat_d = region_q[adr_i[5:2] - 4'h4];
      end
    end
    // Abort capture: a new abort sets sticky flags even during a status read
    if (abort_d) begin
      abort_addr_d = a;
      abort_info_d = 18'h0;
      abort_info_d[memctl_pkg::POS_UNDEF] = undef;
      abort_info_d[memctl_pkg::POS_MISAL] = misal & ~undef;
      abort_info_d[memctl_pkg::POS_ACCESS_PERMISSION] = pviol & ~undef & ~misal;
      abort_info_d[9:8] = sz;
      abort_info_d[11:10] = ty;
      abort_info_d[memctl_pkg::POS_SRC_DMA] = sel_dma;
      abort_info_d[memctl_pkg::POS_SRC_CPU] = ~sel_dma;
      if (sel_dma) sticky_dma_d = 1'b1;
      else sticky_cpu_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remap_q <= 1'b0;
      access_permission_en_q <= 1'b0;
      periph_access_permission_q <= 2'h0;
      for (int i = 0; i < memctl_pkg::NUM_REGIONS; i++) region_q[i] <= memctl_pkg::RST_ZERO;
      abort_addr_q <= memctl_pkg::RST_ZERO;
      abort_info_q <= 18'h0;
      sticky_dma_q <= 1'b0;
      sticky_cpu_q <= 1'b0;
      dat_q <= memctl_pkg::RST_ZERO;
      ack_q <= 1'b0;
    end else begin
      remap_q <= remap_d;
      access_permission_en_q <= access_permission_en_d;
      periph_access_permission_q <= periph_access_permission_d;
      region_q <= region_d;
      abort_addr_q <= abort_addr_d;
      abort_info_q <= abort_info_d;
      sticky_dma_q <= sticky_dma_d;
      sticky_cpu_q <= sticky_cpu_d;
      dat_q <= dat_d;
      ack_q <= ack_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign dma_grant_o = dma_grant_q;
  assign cpu_grant_o = cpu_grant_q;
  assign abort_o = abort_q;
  assign target_o = target_q;
  assign chip_select_o = cs_q;
  assign mem_addr_o = maddr_q;

  // Checks
  property p_dma_priority;
    @(posedge clk_i) disable iff (rst_i) dma_req_i |=> dma_grant_o && !cpu_grant_o;
  endproperty
  a_dma_priority: assert property (p_dma_priority) else $error("dma not favoured");
  property p_undef_abort;
    @(posedge clk_i) disable iff (rst_i)
      (sel_any && a[31:28] > 4'h8 && a[31:28] < 4'hF) |=> abort_o && target_o == 3'h0;
  endproperty
  a_undef_abort: assert property (p_undef_abort) else $error("undefined range no abort");
  property p_cs;
    @(posedge clk_i) disable iff (rst_i)
      (sel_any && !abort_d && a[31:28] == 4'h3) |=> chip_select_o == 8'h04;
  endproperty
  a_cs: assert property (p_cs) else $error("wrong chip select");
  property p_addr_cap;
    @(posedge clk_i) disable iff (rst_i) abort_d |=> abort_addr_q == $past(a);
  endproperty
  a_addr_cap: assert property (p_addr_cap) else $error("abort address lost");
  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (abort_d && !sel_dma) |=> sticky_cpu_q && abort_info_q[memctl_pkg::POS_SRC_CPU];
  endproperty
  a_sticky: assert property (p_sticky) else $error("cpu sticky missing");
  property p_misal;
    @(posedge clk_i) disable iff (rst_i)
      (sel_any && ty != 2'h2 && sz == 2'h2 && a[1:0] != 2'h0) |=> abort_o;
  endproperty
  a_misal: assert property (p_misal) else $error("misaligned word passed");
  property p_access_permission_off;
    @(posedge clk_i) disable iff (rst_i)
      (!access_permission_en_q && sel_any && !undef && !misal) |=> !abort_o;
  endproperty
  a_access_permission_off: assert property (p_access_permission_off) else $error("protection while disabled");
  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
      (wr_acc && adr_i == 8'h00 && sel_i[0] && dat_i[0]) |=> remap_q != $past(remap_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("remap not toggled");
  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      (rd_acc && adr_i == 8'h04 && !abort_d) |=> !sticky_dma_q && !sticky_cpu_q;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky not cleared");
  // Register bus: one take per request, ack a single-cycle pulse
  sequence s_bus_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_once;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) s_bus_take |=> s_ack_once;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
  property p_one_grant;
    @(posedge clk_i) disable iff (rst_i) !(dma_grant_o && cpu_grant_o);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("both masters granted");
  property p_abort_cancel;
    @(posedge clk_i) disable iff (rst_i) abort_o |-> target_o == 3'h0 && chip_select_o == 8'h00;
  endproperty
  a_abort_cancel: assert property (p_abort_cancel) else $error("aborted access routed");
  property p_periph_route;
    @(posedge clk_i) disable iff (rst_i)
      (sel_any && !abort_d && a[31:28] == 4'hF) |=> target_o == 3'h5;
  endproperty
  a_periph_route: assert property (p_periph_route) else $error("peripheral not routed");
  property p_internal_alias;
    @(posedge clk_i) disable iff (rst_i)
      (sel_any && a[31:28] == 4'h0) |=> mem_addr_o[31:20] == 12'h000;
  endproperty
  a_internal_alias: assert property (p_internal_alias) else $error("slot not aliased");
  property p_remap_zero;
    @(posedge clk_i) disable iff (rst_i)
      (wr_acc && adr_i == memctl_pkg::OFF_REMAP && !wdat[0]) |=> $stable(remap_q);
  endproperty
  a_remap_zero: assert property (p_remap_zero) else $error("remap moved on zero");
  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
      !sel_any |=> target_o == 3'h0 && chip_select_o == 8'h00 && !abort_o;
  endproperty
  a_idle: assert property (p_idle) else $error("output without request");
  property p_one_source;
    @(posedge clk_i) disable iff (rst_i)
      abort_d |=> abort_info_q[memctl_pkg::POS_SRC_DMA] != abort_info_q[memctl_pkg::POS_SRC_CPU];
  endproperty
  a_one_source: assert property (p_one_source) else $error("abort source ambiguous");

endmodule // bus_memory_controller

/* File: verilog/memctl_pkg.sv */
// Package with register map, field layout and region codes of the bus memory controller
package memctl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REMAP = 8'h00;
  localparam logic [7:0] OFF_ABORT_STATUS = 8'h04;
  localparam logic [7:0] OFF_ABORT_ADDR = 8'h08;
  localparam logic [7:0] OFF_REGION0 = 8'h10;
  localparam logic [7:0] OFF_PERIPH_ACCESS_PERMISSION = 8'h50;
  localparam logic [7:0] OFF_ACCESS_PERMISSION_ENABLE = 8'h54;
  localparam logic [7:0] OFF_BOOT_STATUS = 8'h58;
  localparam int NUM_REGIONS = 16;
  // Abort status field positions
  localparam int POS_UNDEF = 0;
  localparam int POS_MISAL = 1;
  localparam int POS_ACCESS_PERMISSION = 2;
  localparam int POS_SIZE = 8;
  localparam int POS_TYPE = 10;
  localparam int POS_SRC_DMA = 16;
  localparam int POS_SRC_CPU = 17;
  localparam int POS_STICKY_DMA = 24;
  localparam int POS_STICKY_CPU = 25;
  // Region register field positions
  localparam int POS_BASE_LO = 10;
  localparam int POS_BASE_HI = 21;
  localparam int POS_RSIZE = 4;
  // Access sizes and types
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] TY_READ = 2'h0;
  localparam logic [1:0] TY_WRITE = 2'h1;
  localparam logic [1:0] TY_FETCH = 2'h2;
  // Address map top nibbles
  localparam logic [3:0] NIB_INTERNAL = 4'h0;
  localparam logic [3:0] NIB_CS_LAST = 4'h8;
  localparam logic [3:0] NIB_PERIPH = 4'hF;
  localparam int NUM_AREAS = 11;
  // Internal 1-Mbyte slots (address bits 27:20)
  localparam logic [7:0] SLOT_AREA0 = 8'h00;
  localparam logic [7:0] SLOT_FLASH = 8'h01;
  localparam logic [7:0] SLOT_SRAM = 8'h02;
  localparam logic [7:0] SLOT_ROM = 8'h03;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_ROM, TGT_FLASH, TGT_SRAM, TGT_EXT, TGT_PERIPH
  } target_t;
endpackage
